// ---- logic/hmsel_params.svh ----
// constants of the host interface mode select register block
`ifndef HMSEL_PARAMS_SVH
`define HMSEL_PARAMS_SVH

// register offsets (byte addresses on the 8-bit bus address)
`define HMSEL_ADDR_W 8
`define HMSEL_MODE_OFS 8'h00
`define HMSEL_STAT_OFS 8'h04

// field layout of the mode and status registers
`define HMSEL_MODE_W 3
`define HMSEL_MODE_LSB 0
`define HMSEL_MODE_RST 3'h0
`define HMSEL_STAT_LOADED_BIT 8

// host mode codes
`define HMSEL_CODE_NONE0 3'h0
`define HMSEL_CODE_EPROM 3'h1
`define HMSEL_CODE_MUX 3'h2
`define HMSEL_CODE_INTEL 3'h3
`define HMSEL_CODE_MOTO 3'h4
`define HMSEL_CODE_SERIAL 3'h5

// one-hot select positions and width
`define HMSEL_SEL_W 5
`define HMSEL_SEL_EPROM 0
`define HMSEL_SEL_MUX 1
`define HMSEL_SEL_INTEL 2
`define HMSEL_SEL_MOTO 3
`define HMSEL_SEL_SERIAL 4

// cycles after reset release before the synchronised straps are trusted
`define HMSEL_LOAD_WAIT 2'h2

// bus responses
`define HMSEL_RESP_OKAY 2'h0
`define HMSEL_RESP_SLVERR 2'h2

`endif

// ---- logic/hmsel_pkg.sv ----
// types shared by the host interface mode select block
package hmsel_pkg;
  `include "hmsel_params.svh"

  // host protocol selected by the mode field
  typedef enum logic [2:0] {
    HMSEL_M_UNUSED = `HMSEL_CODE_NONE0,
    HMSEL_M_EPROM = `HMSEL_CODE_EPROM,
    HMSEL_M_MUX = `HMSEL_CODE_MUX,
    HMSEL_M_INTEL = `HMSEL_CODE_INTEL,
    HMSEL_M_MOTO = `HMSEL_CODE_MOTO,
    HMSEL_M_SERIAL = `HMSEL_CODE_SERIAL
  } hmsel_mode_t;

  // complete state of the register block
  typedef struct packed {
    logic [1:0] load_cnt;
    logic loaded;
    logic [2:0] mode;
    logic [2:0] strap;
    logic [`HMSEL_SEL_W-1:0] sel;
    logic aw_rdy;
    logic w_rdy;
    logic aw_got;
    logic w_got;
    logic [`HMSEL_ADDR_W-1:0] waddr;
    logic [2:0] wdata;
    logic wlane;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_rdy;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } hmsel_state_t;
endpackage : hmsel_pkg

// ---- logic/hmsel_sync.sv ----
// two-flop synchroniser for the host mode strap pins
`timescale 1ns/100ps
module hmsel_sync #(
  parameter int W = 3
) (
  input wire logic aclk, // register clock
  input wire logic aresetn, // synchronous reset, active low
  hmsel_sync_if.dut s // raw pins in, synchronised levels out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } hmsel_sync_st_t;

  hmsel_sync_st_t st_reg;
  hmsel_sync_st_t st_next;

  // first stage feeds only the second stage
  always_comb begin
    st_next = st_reg;
    st_next.meta = s.raw;
    st_next.stable = st_reg.meta;
  end

  // reset to constants; the pins are caught only after release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign s.sync = st_reg.stable;
endmodule : hmsel_sync

// ---- logic/hmsel_sync_if.sv ----
// carrier between the strap pins and their synchroniser
`timescale 1ns/100ps
interface hmsel_sync_if #(
  parameter int W = 3
);
  logic [W-1:0] raw;
  logic [W-1:0] sync;
  modport dut (input raw, output sync);
  modport user (output raw, input sync);
endinterface : hmsel_sync_if

// ---- logic/hmsel_top.sv ----
// host interface mode select register with an AXI4-Lite slave
//
// What this block does
// R1: after reset, copy the three strap pins into mode bits; bits 7..3 read zero.
// R2: software writes to the mode register take effect only while in boot-from-EPROM mode.
// R3: mode code 001 selects EPROM boot, 010 selects multiplexed address/data host port.
// R4: code 011 Intel-style, 100 Motorola-style, 101 serial; 000, 110, 111 select nothing.
// R5: once loaded, strap pin changes are ignored; only a register write changes mode.
//
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "hmsel_params.svh"
module hmsel_top
  import hmsel_pkg::*;
(
  input wire logic aclk, // register clock, 125 MHz
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [2:0] strap_pins, // host mode strap pins, asynchronous
  input wire logic [`HMSEL_ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [`HMSEL_ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic [2:0] host_mode, // current host mode field
  output logic mode_valid, // high once the straps have been loaded
  output logic [`HMSEL_SEL_W-1:0] iface_sel // one-hot host protocol select
);

  ////////////////////////////////////////////////////////////////////////////
  // strap synchroniser

  hmsel_sync_if #(.W(3)) strap_if ();

  assign strap_if.raw = strap_pins;

  hmsel_sync #(
    .W(3)
  ) u_strap_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .s(strap_if)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state and handshake terms

  hmsel_state_t st_reg;
  hmsel_state_t st_next;

  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic wr_fire;
  logic [`HMSEL_ADDR_W-1:0] wa_sel;
  logic [2:0] wd_sel;
  logic wl_sel;

  // a channel moves on the edge where valid meets our ready
  assign aw_hs = s_axi_awvalid & st_reg.aw_rdy;
  assign w_hs = s_axi_wvalid & st_reg.w_rdy;
  assign ar_hs = s_axi_arvalid & st_reg.ar_rdy;

  // address and data of a write, taken from the port when they arrive this cycle
  assign wa_sel = aw_hs ? s_axi_awaddr : st_reg.waddr;
  assign wd_sel = w_hs ? s_axi_wdata[2:0] : st_reg.wdata;
  assign wl_sel = w_hs ? s_axi_wstrb[0] : st_reg.wlane;

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb begin
    st_next = st_reg;
    wr_fire = 1'b0;
    if (!st_reg.loaded) begin
      // hold the bus off until the synchroniser holds the released pins
      if (st_reg.load_cnt == `HMSEL_LOAD_WAIT) begin
        st_next.loaded = 1'b1;
        st_next.mode = strap_if.sync; // [R1]
        st_next.strap = strap_if.sync;
        st_next.aw_rdy = 1'b1;
        st_next.w_rdy = 1'b1;
        st_next.ar_rdy = 1'b1;
      end else begin
        st_next.load_cnt = st_reg.load_cnt + 2'h1;
      end
    end else begin
      // write address and data are taken in either order
      if (aw_hs) begin
        st_next.aw_rdy = 1'b0;
        st_next.aw_got = 1'b1;
        st_next.waddr = s_axi_awaddr;
      end
      if (w_hs) begin
        st_next.w_rdy = 1'b0;
        st_next.w_got = 1'b1;
        st_next.wdata = s_axi_wdata[2:0];
        st_next.wlane = s_axi_wstrb[0];
      end
      // both halves present: perform the write and raise the response
      if ((st_reg.aw_got | aw_hs) && (st_reg.w_got | w_hs)) begin
        st_next.aw_got = 1'b0;
        st_next.w_got = 1'b0;
        st_next.bvalid = 1'b1;
        st_next.bresp = `HMSEL_RESP_OKAY;
        if (wa_sel == `HMSEL_MODE_OFS) begin
          // outside EPROM mode the write is answered but dropped, so the
          // protocol cannot be switched away from a live processor port
          if (wl_sel && (st_reg.mode == `HMSEL_CODE_EPROM)) begin // [R2]
            st_next.mode = wd_sel; // [R5]
            wr_fire = 1'b1;
          end
        end else if (wa_sel != `HMSEL_STAT_OFS) begin
          st_next.bresp = `HMSEL_RESP_SLVERR;
        end
      end
      // response taken: reopen both write channels
      if (st_reg.bvalid && s_axi_bready) begin
        st_next.bvalid = 1'b0;
        st_next.aw_rdy = 1'b1;
        st_next.w_rdy = 1'b1;
      end
      // read: one outstanding, answered on the next edge
      if (ar_hs) begin
        st_next.ar_rdy = 1'b0;
        st_next.rvalid = 1'b1;
        st_next.rresp = `HMSEL_RESP_OKAY;
        st_next.rdata = 32'h0000_0000;
        if (s_axi_araddr == `HMSEL_MODE_OFS) begin
          st_next.rdata[`HMSEL_MODE_LSB +: `HMSEL_MODE_W] = st_reg.mode; // [R1]
        end else if (s_axi_araddr == `HMSEL_STAT_OFS) begin
          st_next.rdata[`HMSEL_MODE_LSB +: `HMSEL_MODE_W] = st_reg.strap;
          st_next.rdata[`HMSEL_STAT_LOADED_BIT] = st_reg.loaded;
        end else begin
          st_next.rresp = `HMSEL_RESP_SLVERR;
        end
      end
      if (st_reg.rvalid && s_axi_rready) begin
        st_next.rvalid = 1'b0;
        st_next.ar_rdy = 1'b1;
      end
    end
    // decode the field into a protocol select; unused codes select nothing
    st_next.sel = '0;
    case (st_next.mode)
      `HMSEL_CODE_EPROM: begin
        st_next.sel[`HMSEL_SEL_EPROM] = 1'b1; // [R3]
      end
      `HMSEL_CODE_MUX: begin
        st_next.sel[`HMSEL_SEL_MUX] = 1'b1; // [R3]
      end
      `HMSEL_CODE_INTEL: begin
        st_next.sel[`HMSEL_SEL_INTEL] = 1'b1; // [R4]
      end
      `HMSEL_CODE_MOTO: begin
        st_next.sel[`HMSEL_SEL_MOTO] = 1'b1; // [R4]
      end
      `HMSEL_CODE_SERIAL: begin
        st_next.sel[`HMSEL_SEL_SERIAL] = 1'b1; // [R4]
      end
      default: begin
        st_next.sel = '0; // [R4]
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  // every ready stays low in reset; the mode field resets to zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from the state register

  assign s_axi_awready = st_reg.aw_rdy;
  assign s_axi_wready = st_reg.w_rdy;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = st_reg.ar_rdy;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rresp = st_reg.rresp;
  assign s_axi_rdata = st_reg.rdata;
  assign host_mode = st_reg.mode;
  assign mode_valid = st_reg.loaded;
  assign iface_sel = st_reg.sel;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  // the straps land in the field three edges after reset release
  a_strap_load_time: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
    $rose(aresetn) |-> !mode_valid ##2 !mode_valid ##1 mode_valid)
    else $error("mode not loaded three cycles after reset release");

  // the loaded value is the synchronised strap level
  a_strap_load_value: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
    $rose(mode_valid) |-> host_mode == $past(strap_if.sync))
    else $error("loaded mode differs from strap level");

  // the upper read bits of the mode register are zero
  a_mode_upper_zero: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
    (ar_hs && s_axi_araddr == `HMSEL_MODE_OFS)
      |=> s_axi_rvalid && s_axi_rdata[31:3] == 29'h0 && s_axi_rdata[2:0] == $past(host_mode))
    else $error("mode read returned wrong data");

  // a write takes effect only from EPROM mode, and lands next edge
  a_write_gate: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
    wr_fire |-> host_mode == `HMSEL_CODE_EPROM ##1 host_mode == $past(wd_sel))
    else $error("mode write not gated by EPROM mode");

  // a mode write outside EPROM mode leaves the field alone
  a_write_drop: assert property (@(posedge aclk) disable iff (!aresetn) // [R2]
    ($rose(s_axi_bvalid) && $past(host_mode) != `HMSEL_CODE_EPROM) |-> $stable(host_mode))
    else $error("mode changed outside EPROM mode");

  // EPROM and multiplexed codes decode to their selects
  a_decode_low: assert property (@(posedge aclk) disable iff (!aresetn) // [R3]
    (host_mode == `HMSEL_CODE_EPROM |-> iface_sel == 5'h01)
    and (host_mode == `HMSEL_CODE_MUX |-> iface_sel == 5'h02))
    else $error("EPROM or multiplexed select wrong");

  // parallel and serial codes decode; unused codes select nothing
  a_decode_high: assert property (@(posedge aclk) disable iff (!aresetn) // [R4]
    (host_mode == `HMSEL_CODE_INTEL |-> iface_sel == 5'h04)
    and (host_mode == `HMSEL_CODE_MOTO |-> iface_sel == 5'h08)
    and (host_mode == `HMSEL_CODE_SERIAL |-> iface_sel == 5'h10)
    and (host_mode == `HMSEL_CODE_NONE0 |-> iface_sel == 5'h00)
    and (host_mode > `HMSEL_CODE_SERIAL |-> iface_sel == 5'h00))
    else $error("parallel, serial or unused select wrong");

  // after loading, only a register write moves the field
  a_strap_ignored: assert property (@(posedge aclk) disable iff (!aresetn) // [R5]
    (mode_valid && !wr_fire) |=> $stable(host_mode))
    else $error("mode changed without a register write");

  // every read address is answered on the next edge
  a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_hs |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered in one cycle");

  // nothing is offered or valid at the first edge after release
  a_reset_quiet: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
    $rose(aresetn) |-> !s_axi_awready && !s_axi_wready && !s_axi_arready
      && !s_axi_bvalid && !s_axi_rvalid && !mode_valid && host_mode == 3'h0)
    else $error("outputs not idle after reset release");

  // the bus stays closed until the straps have been loaded
  a_bus_held_off: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
    !mode_valid |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
    else $error("bus ready before strap load");

  // once loaded, the field stays valid until the next reset
  a_valid_stays: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
    mode_valid |=> mode_valid)
    else $error("mode valid dropped without reset");

  // the captured strap copy never moves after loading
  a_strap_frozen: assert property (@(posedge aclk) disable iff (!aresetn) // [R5]
    mode_valid |=> $stable(st_reg.strap))
    else $error("captured strap value changed");

  // at most one protocol is selected at a time
  a_sel_onehot: assert property (@(posedge aclk) disable iff (!aresetn) // [R4]
    $onehot0(iface_sel))
    else $error("more than one protocol selected");

  // address and data together give a response on the next edge
  a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    (aw_hs && w_hs) |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
    else $error("write not answered in one cycle");

  // a taken write response reopens both write channels
  a_write_reopen: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && s_axi_bready) |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write channels not reopened");

  // a taken read response reopens the read address channel
  a_read_reopen: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && s_axi_rready) |=> !s_axi_rvalid && s_axi_arready)
    else $error("read channel not reopened");

  // status read shows the loaded flag and zeros outside its fields
  a_status_read: assert property (@(posedge aclk) disable iff (!aresetn) // [R1]
    (ar_hs && s_axi_araddr == `HMSEL_STAT_OFS)
      |=> s_axi_rdata[31:9] == 23'h0 && s_axi_rdata[8] && s_axi_rdata[7:3] == 5'h00)
    else $error("status read returned wrong data");

  // an unmapped read is refused with zero data
  a_read_unmapped: assert property (@(posedge aclk) disable iff (!aresetn)
    (ar_hs && s_axi_araddr != `HMSEL_MODE_OFS && s_axi_araddr != `HMSEL_STAT_OFS)
      |=> s_axi_rresp == `HMSEL_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");

endmodule : hmsel_top

// ---- tb/hmsel_strap_model.sv ----
// board-side model of the host mode strap pins
`timescale 1ns/100ps
module hmsel_strap_model (
  input wire logic [2:0] level, // level the board sets
  output logic [2:0] strap_pins // pins seen by the device
);
  // jumpers give a settled level, never a floating one, so no unknown reaches the pins
  assign strap_pins = level;
endmodule : hmsel_strap_model

// ---- tb/hmsel_top_tb_top.sv ----
// self-checking bench of the host mode select register
`timescale 1ns/100ps
module hmsel_top_tb_top;
  import hmsel_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [2:0] strap_level = 3'h1;
  logic [2:0] strap_pins;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, mode_valid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [2:0] host_mode;
  logic [4:0] iface_sel;
  int err_total = 0, n_checks = 0, cyc = 0;

  always #4 aclk = ~aclk;

  hmsel_strap_model u_strap (.level(strap_level), .strap_pins(strap_pins));

  hmsel_top DUT (
    .aclk(aclk), .aresetn(aresetn), .strap_pins(strap_pins),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .host_mode(host_mode), .mode_valid(mode_valid), .iface_sel(iface_sel)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // a hung handshake would stall forever, so cap the run
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      summarize();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one-hot select expected for a mode code
  function automatic logic [4:0] sel_of(input logic [2:0] c);
    return (c >= 3'h1 && c <= 3'h5) ? 5'h01 << (c - 3'h1) : 5'h00;
  endfunction : sel_of

  // reset with a strap level, then wait for the load to finish
  task automatic do_reset(input logic [2:0] s);
    @(posedge aclk);
    strap_level <= s;
    aresetn <= 1'h0;
    repeat (6) @(posedge aclk);
    check("reset valid", 32'(mode_valid), 32'h0);
    check("reset mode", 32'(host_mode), 32'h0);
    aresetn <= 1'h1;
    do @(negedge aclk); while (mode_valid !== 1'h1);
  endtask : do_reset

  // outputs sampled at the falling edge, where registered values have settled
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    logic pa, pw, ta, tw, done;
    pa = 1'h1;
    pw = 1'h1;
    done = 1'h0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!done) begin
      @(negedge aclk);
      ta = pa && awready === 1'h1;
      tw = pw && wready === 1'h1;
      done = bvalid === 1'h1;
      r = bresp;
      @(posedge aclk);
      if (ta) begin
        awvalid <= 1'h0;
        pa = 1'h0;
      end
      if (tw) begin
        wvalid <= 1'h0;
        pw = 1'h0;
      end
      if (done) bready <= 1'h0;
    end
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic pa, ta, done;
    pa = 1'h1;
    done = 1'h0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!done) begin
      @(negedge aclk);
      ta = pa && arready === 1'h1;
      done = rvalid === 1'h1;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) begin
        arvalid <= 1'h0;
        pa = 1'h0;
      end
      if (done) rready <= 1'h0;
    end
  endtask : axi_read

  ////////////////////////////////////////////////////////////////////////////////
  // every code through the straps, a write outside or inside boot mode, then a boot write
  task automatic t_codes();
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 8; i++) begin
      do_reset(3'(i));
      check("strap mode", 32'(host_mode), 32'(i));
      check("strap sel", 32'(iface_sel), 32'(sel_of(3'(i))));
      axi_read(8'h00, d, r);
      check("mode read", d, 32'(i));
      check("mode read resp", 32'(r), 32'h0);
      axi_write(8'h00, ~32'(i), 4'hF, r);
      check("write resp", 32'(r), 32'h0);
      check("mode kept", 32'(host_mode), (i == 1) ? 32'h6 : 32'(i));
      do_reset(3'h1);
      axi_write(8'h00, 32'(i), 4'hF, r);
      check("boot write", 32'(host_mode), 32'(i));
      @(negedge aclk);
      check("boot sel", 32'(iface_sel), 32'(sel_of(3'(i))));
    end
    $display("test codes done");
  endtask : t_codes

  // later strap changes, a masked write lane and an unmapped place
  task automatic t_misc();
    logic [31:0] d;
    logic [1:0] r;
    do_reset(3'h3);
    @(posedge aclk);
    strap_level <= 3'h1;
    repeat (8) @(negedge aclk);
    check("strap ignored", 32'(host_mode), 32'h3);
    axi_read(8'h04, d, r);
    check("status data", d, 32'h0000_0103);
    check("status resp", 32'(r), 32'h0);
    do_reset(3'h1);
    axi_write(8'h00, 32'h5, 4'h0, r);
    check("lane off", 32'(host_mode), 32'h1);
    axi_write(8'h04, 32'h2, 4'hF, r);
    check("status write resp", 32'(r), 32'h0);
    check("status write kept", 32'(host_mode), 32'h1);
    axi_write(8'h08, 32'h2, 4'hF, r);
    check("unmapped write resp", 32'(r), 32'h2);
    check("unmapped write kept", 32'(host_mode), 32'h1);
    axi_read(8'h08, d, r);
    check("unmapped resp", 32'(r), 32'h2);
    check("unmapped data", d, 32'h0);
    $display("test misc done");
  endtask : t_misc

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  initial begin
    t_codes();
    t_misc();
    summarize();
  end
endmodule : hmsel_top_tb_top
